/* common/spnv_pkg.sv */
package spnv_pkg;

    // ----------------------------------------
    // opcodes (upper nibble zero, bit 3 is A8 for memory access)
    // ----------------------------------------
    localparam logic [7:0] OPC_SET_LATCH   = 8'h06;
    localparam logic [7:0] OPC_CLR_LATCH   = 8'h04;
    localparam logic [7:0] OPC_STATUS_RD   = 8'h05;
    localparam logic [7:0] OPC_STATUS_WR   = 8'h01;
    localparam logic [2:0] OPC_MEM_RD_LOW  = 3'h3;
    localparam logic [2:0] OPC_MEM_WR_LOW  = 3'h2;
    localparam int         OPC_A8_BIT      = 3;

    // ----------------------------------------
    // status register layout and reset values
    // ----------------------------------------
    localparam int         SR_WEL_BIT      = 1;
    localparam int         SR_BP_LO_BIT    = 2;
    localparam int         SR_BP_HI_BIT    = 3;
    localparam logic       WEL_RESET       = 1'b0;
    localparam logic [1:0] BP_INIT         = 2'h0;

    // ----------------------------------------
    // protected range starts and address space
    // ----------------------------------------
    localparam int         ADDR_W          = 9;
    localparam int         MEM_DEPTH       = 512;
    localparam logic [8:0] PROT_QUARTER    = 9'h180;
    localparam logic [8:0] PROT_HALF       = 9'h100;
    localparam logic [8:0] ADDR_LAST       = 9'h1FF;
    localparam logic [2:0] BIT_LAST        = 3'h7;

    // ----------------------------------------
    // pin synchroniser width
    // ----------------------------------------
    localparam int         SYNC_W          = 5;

endpackage

/* logic/spnv_sync.sv */
`timescale 1ns/100ps
module spnv_sync (
    input  wire logic                          clk,
    input  wire logic                          rst,
    input  wire logic [spnv_pkg::SYNC_W-1:0]   pins_in,
    output logic      [spnv_pkg::SYNC_W-1:0]   pins_out
);

    // ----------------------------------------
    // two-flop synchroniser, first stage feeds only the second
    // ----------------------------------------
    typedef struct packed {
        logic [spnv_pkg::SYNC_W-1:0] meta;
        logic [spnv_pkg::SYNC_W-1:0] stable;
    } spnv_sync_t;

    spnv_sync_t sync_reg;
    spnv_sync_t sync_next;

    always_comb begin
        sync_next        = sync_reg;
        sync_next.meta   = pins_in;
        sync_next.stable = sync_reg.meta;
    end

    // select, hold and protect pins idle high, so reset all pins to ones to avoid a false select
    always_ff @(posedge clk) begin
        if (rst) begin
            sync_reg <= '1;
        end else begin
            sync_reg <= sync_next;
        end
    end

    assign pins_out = sync_reg.stable;

endmodule

/* logic/spnv_nv_store.sv */
`timescale 1ns/100ps
module spnv_nv_store (
    input  wire logic       clk,
    input  wire logic       mem_we,
    input  wire logic [8:0] wr_addr,
    input  wire logic [7:0] wr_data,
    input  wire logic [8:0] rd_addr,
    output logic      [7:0] rd_data,
    input  wire logic       bp_we,
    input  wire logic [1:0] bp_in,
    output logic      [1:0] bp
);

    // ----------------------------------------
    // nonvolatile array and block guard bits
    // ----------------------------------------
    // no reset here on purpose: contents must survive the power-up reset
    typedef struct packed {
        logic [spnv_pkg::MEM_DEPTH-1:0][7:0] cells;
        logic [1:0]                          guard;
    } spnv_nv_t;

    spnv_nv_t nv_reg = '{cells: '0, guard: spnv_pkg::BP_INIT};
    spnv_nv_t nv_next;

    always_comb begin
        nv_next = nv_reg;
        if (mem_we) begin
            nv_next.cells[wr_addr] = wr_data;
        end
        if (bp_we) begin
            nv_next.guard = bp_in;
        end
    end

    always_ff @(posedge clk) begin
        nv_reg <= nv_next;
    end

    assign rd_data = nv_reg.cells[rd_addr];
    assign bp      = nv_reg.guard;

endmodule

/* logic/spnv_top.sv */
// Overview of operation
// - status bits 0 and 4..7 always read zero and cannot be written.
// - status bit 1 shows the write latch; latch is clear after power-up.
// - status data never touches the latch; set, clear, status-write and write commands do.
// - both block guard bits are held in nonvolatile storage.
// - guard 00 none, 01 180h-1FFh, 10 100h-1FFh, 11 whole array.
// - guard ranges apply only with protect pin high and latch set.
// - latch clear rejects every array and status write.
// - protect pin low blocks status and array writes even with latch set.
// - status read command shifts out current status, repeated while clocked.
// - status write (after latch set, pin high) updates guards, clears latch.
// - write opcode carries A8 in bit 3, then low address, then data.
// - burst address advances per byte and wraps 1FFh to 000h.
// - each write byte commits right after its eighth bit.
// - burst write hitting a guarded address stops and drops further bytes.
// - chip select rise ends a write; a partial byte is dropped.
// - read opcode with A8, low address, then data out; input ignored.
// - chip select rise ends a read and floats the serial output.
// - bytes move most significant bit first in both directions.
// - hold low with clock low pauses; hold high with clock low resumes.
// - six opcodes: 06, 04, 05, 01, 0A011b read, 0A010b write.
// - latch clears on select rise ending clear, status-write or write.
// - unknown opcode: ignore rest until next select fall, output floats.
// - clock level at select fall picks mode 0 or 3; rise in, fall out.
`timescale 1ns/100ps
module spnv_top (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic cs_n,
    input  wire logic sck,
    input  wire logic si,
    input  wire logic hold_n,
    input  wire logic wp_n,
    output logic      so,
    output logic      so_oe
);

    // ----------------------------------------
    // types
    // ----------------------------------------
    typedef enum logic [2:0] {
        PH_IDLE,
        PH_OPCODE,
        PH_ADDR,
        PH_WDATA,
        PH_RDATA,
        PH_SR_WRITE,
        PH_SR_READ,
        PH_IGNORE
    } spnv_phase_t;

    typedef struct packed {
        spnv_phase_t phase;
        logic [2:0]  bit_cnt;
        logic [7:0]  in_sh;
        logic [7:0]  out_sh;
        logic [8:0]  addr;
        logic        a8;
        logic        is_read;
        logic        write_latch_flag;
        logic        clr_pend;
        logic        stopped;
        logic        held;
        logic        mode3;
        logic        rise_seen;
        logic        drive;
        logic        sck_prev;
        logic        cs_prev;
        logic        so;
        logic        so_oe;
    } spnv_state_t;

    // ----------------------------------------
    // functions
    // ----------------------------------------
    function automatic logic [7:0] status_byte(input logic wel_f, input logic [1:0] bp_f);
        logic [7:0] s;
        s                        = 8'h00;
        s[spnv_pkg::SR_WEL_BIT]  = wel_f;
        s[spnv_pkg::SR_BP_LO_BIT] = bp_f[0];
        s[spnv_pkg::SR_BP_HI_BIT] = bp_f[1];
        return s;
    endfunction

    function automatic logic guarded(input logic [1:0] bp_f, input logic [8:0] a);
        logic g;
        unique case (bp_f)
            2'b00: g = 1'b0;
            2'b01: g = (a >= spnv_pkg::PROT_QUARTER);
            2'b10: g = (a >= spnv_pkg::PROT_HALF);
            2'b11: g = 1'b1;
        endcase
        return g;
    endfunction

    // memory opcodes carry A8 in bit 3, so only the outer bits are compared
    function automatic logic mem_opcode(input logic [7:0] op, input logic [2:0] low);
        logic m;
        m = (op[7:4] == 4'h0) && (op[2:0] == low);
        return m;
    endfunction

    // a mode 3 frame opens with the clock high; its first fall carries no data
    function automatic logic fall_valid(input logic m3, input logic seen);
        logic v;
        v = seen | ~m3;
        return v;
    endfunction

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    logic [spnv_pkg::SYNC_W-1:0] pins_s;
    logic                        cs_n_s;
    logic                        sck_s;
    logic                        si_s;
    logic                        hold_n_s;
    logic                        wp_n_s;

    spnv_sync u_sync (
        .clk      (clk),
        .rst      (rst),
        .pins_in  ({cs_n, sck, si, hold_n, wp_n}),
        .pins_out (pins_s)
    );

    assign {cs_n_s, sck_s, si_s, hold_n_s, wp_n_s} = pins_s;

    // ----------------------------------------
    // nonvolatile storage
    // ----------------------------------------
    logic       mem_we;
    logic [7:0] wr_data;
    logic [8:0] rd_addr;
    logic [7:0] rd_data;
    logic       bp_we;
    logic [1:0] bp_in;
    logic [1:0] bp;

    spnv_state_t st_reg;
    spnv_state_t st_next;

    spnv_nv_store u_nv (
        .clk     (clk),
        .mem_we  (mem_we),
        .wr_addr (st_reg.addr),
        .wr_data (wr_data),
        .rd_addr (rd_addr),
        .rd_data (rd_data),
        .bp_we   (bp_we),
        .bp_in   (bp_in),
        .bp      (bp)
    );

    // ----------------------------------------
    // serial engine
    // ----------------------------------------
    logic       sck_rise;
    logic       sck_fall;
    logic       byte_done;
    logic [7:0] in_byte;
    logic [8:0] new_addr;
    logic       wr_allowed;

    always_comb begin
        st_next    = st_reg;
        mem_we     = 1'b0;
        bp_we      = 1'b0;
        bp_in      = bp;
        rd_addr    = st_reg.addr;
        // paused frames see no clock edges at all
        sck_rise   = sck_s & ~st_reg.sck_prev & ~st_reg.held;
        sck_fall   = ~sck_s & st_reg.sck_prev & ~st_reg.held;
        in_byte    = {st_reg.in_sh[6:0], si_s};
        byte_done  = sck_rise && (st_reg.bit_cnt == spnv_pkg::BIT_LAST);
        new_addr   = {st_reg.a8, in_byte};
        wr_allowed = st_reg.write_latch_flag & wp_n_s;
        wr_data    = in_byte;

        st_next.sck_prev = sck_s;
        st_next.cs_prev  = cs_n_s;

        if (cs_n_s) begin
            // select high: frame ends, partial byte dropped, output floats
            if (!st_reg.cs_prev && st_reg.clr_pend) begin
                st_next.write_latch_flag = 1'b0;
            end
            st_next.phase    = PH_IDLE;
            st_next.clr_pend = 1'b0;
            st_next.held     = 1'b0;
            st_next.drive    = 1'b0;
            st_next.bit_cnt  = 3'h0;
        end else if (st_reg.cs_prev) begin
            // select fall: a new opcode begins, mode taken from clock level
            st_next.phase    = PH_OPCODE;
            st_next.mode3    = sck_s;
            st_next.rise_seen = 1'b0;
            st_next.bit_cnt  = 3'h0;
            st_next.stopped  = 1'b0;
            st_next.drive    = 1'b0;
            st_next.held     = 1'b0;
        end else begin
            // hold is only honoured with the clock low
            if (!sck_s) begin
                st_next.held = ~hold_n_s;
            end

            if (sck_rise && st_reg.phase != PH_IDLE && st_reg.phase != PH_IGNORE) begin
                st_next.in_sh   = in_byte;
                st_next.bit_cnt = st_reg.bit_cnt + 3'h1;
            end

            if (sck_rise) begin
                st_next.rise_seen = 1'b1;
            end

            if (byte_done) begin
                unique case (st_reg.phase)
                    PH_OPCODE: begin
                        st_next.a8 = in_byte[spnv_pkg::OPC_A8_BIT];
                        if (in_byte == spnv_pkg::OPC_SET_LATCH) begin
                            st_next.write_latch_flag   = 1'b1;
                            st_next.phase = PH_IGNORE;
                        end else if (in_byte == spnv_pkg::OPC_CLR_LATCH) begin
                            st_next.clr_pend = 1'b1;
                            st_next.phase    = PH_IGNORE;
                        end else if (in_byte == spnv_pkg::OPC_STATUS_RD) begin
                            st_next.out_sh = status_byte(st_reg.write_latch_flag, bp);
                            st_next.phase  = PH_SR_READ;
                        end else if (in_byte == spnv_pkg::OPC_STATUS_WR) begin
                            st_next.clr_pend = 1'b1;
                            st_next.phase    = PH_SR_WRITE;
                        end else if (mem_opcode(in_byte, spnv_pkg::OPC_MEM_RD_LOW)) begin
                            st_next.is_read = 1'b1;
                            st_next.phase   = PH_ADDR;
                        end else if (mem_opcode(in_byte, spnv_pkg::OPC_MEM_WR_LOW)) begin
                            st_next.is_read  = 1'b0;
                            st_next.clr_pend = 1'b1;
                            st_next.phase    = PH_ADDR;
                        end else begin
                            st_next.phase = PH_IGNORE;
                        end
                    end
                    PH_ADDR: begin
                        st_next.addr = new_addr;
                        if (st_reg.is_read) begin
                            rd_addr        = new_addr;
                            st_next.out_sh = rd_data;
                            st_next.addr   = new_addr + 9'h001;
                            st_next.phase  = PH_RDATA;
                        end else begin
                            st_next.phase  = PH_WDATA;
                        end
                    end
                    PH_WDATA: begin
                        // writes land byte by byte; a guarded hit freezes the burst
                        if (!wr_allowed) begin
                            st_next.stopped = 1'b1;
                        end else if (st_reg.stopped || guarded(bp, st_reg.addr)) begin
                            st_next.stopped = 1'b1;
                        end else begin
                            mem_we       = 1'b1;
                            st_next.addr = st_reg.addr + 9'h001;
                        end
                    end
                    PH_RDATA: begin
                        st_next.out_sh = rd_data;
                        st_next.addr   = st_reg.addr + 9'h001;
                    end
                    PH_SR_WRITE: begin
                        if (wr_allowed) begin
                            bp_we = 1'b1;
                            bp_in = {in_byte[spnv_pkg::SR_BP_HI_BIT],
                                     in_byte[spnv_pkg::SR_BP_LO_BIT]};
                        end
                        st_next.phase = PH_IGNORE;
                    end
                    PH_SR_READ: begin
                        // repeat status while the master keeps clocking
                        st_next.out_sh = status_byte(st_reg.write_latch_flag, bp);
                    end
                    default: begin
                        st_next.phase = st_reg.phase;
                    end
                endcase
            end

            // output bits change on falling edges only, msb first
            if (sck_fall && fall_valid(st_reg.mode3, st_reg.rise_seen)
                && (st_reg.phase == PH_RDATA || st_reg.phase == PH_SR_READ)) begin
                st_next.so     = st_reg.out_sh[7];
                st_next.out_sh = {st_reg.out_sh[6:0], 1'b0};
                st_next.drive  = 1'b1;
            end
        end

        // floats while deselected, paused, or in ignored frames
        st_next.so_oe = st_next.drive & ~st_next.held & ~cs_n_s;
    end

    // ----------------------------------------
    // state register
    // ----------------------------------------
    // reset clears only volatile state; guards and array live in the store
    always_ff @(posedge clk) begin
        if (rst) begin
            st_reg          <= '0;
            st_reg.phase    <= PH_IDLE;
            st_reg.write_latch_flag      <= spnv_pkg::WEL_RESET;
            st_reg.sck_prev <= 1'b0;
            st_reg.cs_prev  <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    // both pins come straight from the state register, no gating after it
    assign so    = st_reg.so;
    assign so_oe = st_reg.so_oe;

endmodule

/* tb/spnv_properties.sv */
`timescale 1ns/100ps
module spnv_properties (
    input wire logic clk,
    input wire logic rst,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic si,
    input wire logic hold_n,
    input wire logic wp_n,
    input wire logic so,
    input wire logic so_oe
);
    // ----------------------------------------
    // ages of raw pin events
    // ----------------------------------------
    // raw pins lead the synchronised view, so every bound leaves slack
    logic       sck_q;
    logic [7:0] fall_age;
    logic [7:0] hold_age;
    logic [7:0] quiet_age;
    logic [7:0] rise_cnt;

    function automatic logic [7:0] inc(input logic [7:0] v);
        return (v == 8'hFF) ? v : v + 8'h01;
    endfunction

    always_ff @(posedge clk) begin
        sck_q     <= sck;
        fall_age  <= (sck_q && !sck) ? 8'h00 : inc(fall_age);
        hold_age  <= !hold_n ? 8'h00 : inc(hold_age);
        quiet_age <= (cs_n || !hold_n) ? 8'h00 : inc(quiet_age);
        if (rst || cs_n) begin
            rise_cnt <= 8'h00;
        end else if (!sck_q && sck && hold_n) begin
            rise_cnt <= inc(rise_cnt);
        end
        if (rst) begin
            fall_age <= 8'hFF;
            hold_age <= 8'hFF;
        end
    end

    default clocking @(posedge clk);
    endclocking
    default disable iff (rst);

    // ----------------------------------------
    // output pin behaviour
    // ----------------------------------------
    reset_quiet_a: assert property (disable iff (1'b0) rst |=> !so_oe && !so)
        else $error("output active after reset");
    deselect_float_a: assert property (cs_n [*8] |-> !so_oe)
        else $error("output driven while deselected");
    hold_float_a: assert property (!hold_n [*8] |-> !so_oe)
        else $error("output driven during hold");
    so_timing_a: assert property (so_oe && $past(so_oe) && so != $past(so)
        |-> fall_age < 8'd8 || hold_age < 8'd32)
        else $error("output changed away from a falling clock");
    oe_rise_a: assert property ($rose(so_oe) |-> !cs_n && (fall_age < 8'd8 || hold_age < 8'd32))
        else $error("output enable rose without a falling clock");
    opcode_count_a: assert property ($rose(so_oe) && hold_age > 8'd40
        |-> rise_cnt inside {8'd8, 8'd9, 8'd16, 8'd17})
        else $error("output started off a byte boundary");
    oe_fall_a: assert property ($fell(so_oe) |-> quiet_age < 8'd8)
        else $error("output released without deselect or hold");
endmodule

/* tb/spnv_master.sv */
`timescale 1ns/100ps
module spnv_master (
    input  wire logic clk,
    input  wire logic so_line,
    output logic      cs_n,
    output logic      sck,
    output logic      si,
    output logic      hold_n,
    output logic      wp_n
);
    logic mode;

    initial begin
        cs_n   = 1'b1;
        sck    = 1'b0;
        si     = 1'b0;
        hold_n = 1'b1;
        wp_n   = 1'b1;
        mode   = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    // idle clock level at select fall chooses the mode
    task automatic sel(input logic m3);
        mode = m3;
        sck  <= m3;
        tick(4);
        cs_n <= 1'b0;
        tick(4);
    endtask

    // released data line flips so a stale value is never mistaken for data
    task automatic desel;
        sck <= mode;
        tick(4);
        cs_n <= 1'b1;
        si   <= ~si;
        tick(6);
    endtask

    // msb first; hold moves only with the clock low, clock toggles during hold
    task automatic xfer(input logic [7:0] tx, input int nb, input int hb,
                        output logic [7:0] rx);
        rx = 8'hzz;
        for (int i = 7; i > 7 - nb; i--) begin
            sck <= 1'b0;
            si  <= tx[i];
            tick(4);
            if (i == hb) begin
                hold_n <= 1'b0;
                si     <= ~tx[i];
                tick(4);
                sck <= 1'b1;
                tick(4);
                sck <= 1'b0;
                tick(4);
                hold_n <= 1'b1;
                si     <= tx[i];
                tick(4);
            end
            sck <= 1'b1;
            tick(4);
            rx[i] = so_line;
        end
    endtask
endmodule

/* tb/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    wire        cs_n, sck, si, hold_n, wp_n, so, so_oe;
    wire        so_line = so_oe ? so : 1'bz;
    int         n_mismatch = 0;
    int         num_checks = 0;
    logic [7:0] ref_mem [512];
    logic [7:0] r[$];

    always #10 clk = ~clk;

    spnv_top spnv_top_inst (.clk(clk), .rst(rst), .cs_n(cs_n), .sck(sck), .si(si),
        .hold_n(hold_n), .wp_n(wp_n), .so(so), .so_oe(so_oe));
    spnv_master spnv_master_inst (.clk(clk), .so_line(so_line), .cs_n(cs_n), .sck(sck),
        .si(si), .hold_n(hold_n), .wp_n(wp_n));

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic complete_run;
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic reset_dut;
        rst <= 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
    endtask

    task automatic frame(input logic m3, input logic [7:0] b[$], output logic [7:0] rx[$],
                         input int nbl = 8, input int hb = -1);
        logic [7:0] v;
        rx = {};
        spnv_master_inst.sel(m3);
        foreach (b[k]) begin
            spnv_master_inst.xfer(b[k], (k == b.size() - 1) ? nbl : 8,
                                  (k == b.size() - 1) ? hb : -1, v);
            rx.push_back(v);
        end
        spnv_master_inst.desel();
    endtask

    function automatic logic [7:0] mop(input logic [8:0] a, input logic [2:0] k);
        return {4'h0, a[8], k};
    endfunction

    task automatic latch;
        frame(0, '{spnv_pkg::OPC_SET_LATCH}, r);
    endtask

    task automatic wr_st(input logic [7:0] v);
        latch();
        frame(0, '{spnv_pkg::OPC_STATUS_WR, v}, r);
    endtask

    task automatic st_chk(input logic [7:0] exp);
        frame(0, '{spnv_pkg::OPC_STATUS_RD, 8'h00}, r);
        chk(r[1], exp);
    endtask

    // ok = leading bytes expected to land
    task automatic mem_wr(input logic [8:0] a, input int n, input logic [7:0] d, input int ok);
        logic [7:0] q[$];
        latch();
        q = '{mop(a, spnv_pkg::OPC_MEM_WR_LOW), a[7:0]};
        for (int i = 0; i < n; i++) begin
            q.push_back(d + 8'(i));
            if (i < ok) ref_mem[a + 9'(i)] = d + 8'(i);
        end
        frame(0, q, r);
    endtask

    task automatic mem_rd(input logic [8:0] a, input int n, input logic m3 = 0,
                          input int hb = -1);
        logic [7:0] q[$];
        q = '{mop(a, spnv_pkg::OPC_MEM_RD_LOW), a[7:0]};
        repeat (n) q.push_back(8'hFF);
        frame(m3, q, r, 8, hb);
        for (int i = 0; i < n; i++) chk(r[i + 2], ref_mem[a + 9'(i)]);
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_status;
        st_chk(8'h00);
        frame(0, '{spnv_pkg::OPC_SET_LATCH, spnv_pkg::OPC_CLR_LATCH}, r);
        st_chk(8'h02);
        frame(0, '{spnv_pkg::OPC_CLR_LATCH}, r);
        st_chk(8'h00);
        frame(0, '{spnv_pkg::OPC_STATUS_WR, 8'hFF}, r);
        st_chk(8'h00);
        wr_st(8'hFF);
        st_chk(8'h0C);
        spnv_master_inst.wp_n <= 1'b0;
        wr_st(8'h00);
        st_chk(8'h0C);
        spnv_master_inst.wp_n <= 1'b1;
        wr_st(8'hF3);
        st_chk(8'h00);
        wr_st(8'h08);
        reset_dut();
        st_chk(8'h08);
        wr_st(8'h00);
    endtask

    task automatic t_mem;
        mem_wr(9'h1FE, 3, 8'hA0, 3);
        st_chk(8'h00);
        mem_rd(9'h1FE, 3);
        frame(0, '{mop(9'h1FE, spnv_pkg::OPC_MEM_WR_LOW), 8'hFE, 8'h55}, r);
        mem_rd(9'h1FE, 1);
        spnv_master_inst.wp_n <= 1'b0;
        mem_wr(9'h1FE, 1, 8'h66, 0);
        spnv_master_inst.wp_n <= 1'b1;
        mem_rd(9'h1FE, 1);
        mem_wr(9'h050, 2, 8'h11, 2);
        latch();
        frame(0, '{mop(9'h050, spnv_pkg::OPC_MEM_WR_LOW), 8'h50, 8'h3C, 8'hFF}, r, 5);
        ref_mem[9'h050] = 8'h3C;
        mem_rd(9'h050, 2);
        mem_rd(9'h050, 2, 1, 3);
        frame(0, '{8'h07, 8'h05, 8'h00}, r);
        chk(r[2], 8'hzz);
    endtask

    task automatic t_guard;
        logic [8:0] s[4] = '{9'h17E, 9'h17E, 9'h0FE, 9'h000};
        int         ok[4] = '{4, 2, 2, 0};
        for (int g = 0; g < 4; g++) begin
            wr_st(8'h00);
            mem_wr(s[g], 4, 8'h10, 4);
            wr_st({4'h0, g[1:0], 2'h0});
            mem_wr(s[g], 4, 8'h80 + 8'(g), ok[g]);
            mem_rd(s[g], 4);
        end
        wr_st(8'h00);
    endtask

    initial begin
        reset_dut();
        t_status();
        t_mem();
        t_guard();
        complete_run();
    end

    // whole run needs roughly a seventh of this span
    initial begin
        repeat (90000) @(posedge clk);
        n_mismatch++;
        complete_run();
    end
endmodule

bind spnv_top spnv_properties spnv_properties_inst (.clk(clk), .rst(rst), .cs_n(cs_n),
    .sck(sck), .si(si), .hold_n(hold_n), .wp_n(wp_n), .so(so), .so_oe(so_oe));
